/* File: common/mmu_regs_pkg.sv */
package mmu_regs_pkg;
  // register select codes on the mm register port
  localparam logic [2:0] SEL_BASE_ZERO  = 3'h0;
  localparam logic [2:0] SEL_BASE_ONE   = 3'h1;
  localparam logic [2:0] SEL_PURGE_ZERO = 3'h2;
  localparam logic [2:0] SEL_PURGE_ONE  = 3'h3;
  localparam logic [2:0] SEL_FAULT_ADDR = 3'h4;
  localparam logic [2:0] SEL_CONTROL    = 3'h5;
  localparam logic [2:0] SEL_STATUS     = 3'h6;
  localparam int unsigned REG_COUNT     = 7;
  // page geometry
  localparam int unsigned PAGE_BYTES    = 4096;
  localparam int unsigned OFFSET_W      = $clog2(PAGE_BYTES);
  localparam int unsigned FRAME_W       = 32 - OFFSET_W;
  // control field positions
  localparam int unsigned CTL_USER      = 0;
  localparam int unsigned CTL_SUPER     = 1;
  localparam int unsigned CTL_DUAL      = 2;
  localparam int unsigned CTL_OVERRIDE  = 3;
  localparam int unsigned CTL_W         = 4;
  localparam logic [3:0] CTL_RESET      = 4'h0;
  // status field positions
  localparam int unsigned ST_CAUSE_LO   = 0;
  localparam int unsigned ST_DIR        = 2;
  localparam int unsigned ST_ORIGIN     = 3;
  localparam int unsigned ST_CYCLE_LO   = 4;
  localparam int unsigned ST_W          = 8;
  localparam logic [7:0] ST_RESET       = 8'h00;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  // fault cause codes
  localparam logic [1:0] CAUSE_NONE     = 2'h0;
  localparam logic [1:0] CAUSE_L1       = 2'h1;
  localparam logic [1:0] CAUSE_L2       = 2'h2;
  localparam logic [1:0] CAUSE_PROT     = 2'h3;
  // cycle type codes
  localparam logic [3:0] CYC_SEQ_FETCH  = 4'h8;
  localparam logic [3:0] CYC_JMP_FETCH  = 4'h9;
  localparam logic [3:0] CYC_DATA       = 4'hA;
  localparam logic [3:0] CYC_RMW_READ   = 4'hB;
  localparam logic [3:0] CYC_EA_READ    = 4'hC;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } mmr_req_t;

  typedef struct packed {
    logic        valid;
    logic        needed;
    logic        pte1_bad;
    logic        pte2_bad;
    logic        prot;
    logic        write;
    logic        user;
    logic [3:0]  cycle;
    logic [31:0] vaddr;
  } fault_rpt_t;

  typedef struct packed {
    logic        by_vaddr;
    logic        by_base;
    logic        space;
    logic [31:0] addr;
  } purge_cmd_t;
endpackage

/* File: hw/mmu_control_status_regs.sv */
`timescale 1ns/1ps
// What this block does
// - seven mm registers via load/store insns; both purge registers write-only
// - page-table base registers keep low 12 bits at zero
// - loading a base register purges TLB entries made with its old value
// - writing a purge register removes that virtual address translation if present
// - clearing translate enables purges nothing
// - translation exception loads fault address with full 32-bit virtual address
// - fault address unchanged by faults on discarded prefetches
// - control holds four bits; bits 4 to 31 read zero
// - user enable bit turns user-mode translation on or off
// - supervisor enable bit turns supervisor-mode translation on or off
// - dual space: user uses base one, else both use base zero
// - override bit checks user accesses with supervisor privilege
// - status holds eight bits; upper writes ignored, read zero
// - status updates only for faults on needed references
// - cause codes: none, level-1 invalid, level-2 invalid, protection
// - protection violation wins over invalid entry in cause field
// - direction bit records read zero, write one
// - origin bit set for user reference, clear for supervisor
// - cycle type field records faulting access kind code
// - cycle type undefined for interrupt acknowledge faults
// - 32-bit virtual to physical mapping with 4096-byte pages
// - fault on needed reference raises abort trap
// - mm instructions disabled raise undefined-instruction trap instead
module mmu_control_status_regs (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic                     mm_insn_enable,
  input  wire mmu_regs_pkg::mmr_req_t   mmr_req,
  output logic                          mmr_ack,
  output logic [31:0]                   mmr_rdata,
  output logic                          undefined_insn_trap,
  input  wire mmu_regs_pkg::fault_rpt_t fault,
  output logic                          abort_trap,
  output mmu_regs_pkg::purge_cmd_t      purge,
  input  wire logic                     xlat_user,
  input  wire logic [31:0]              xlat_vaddr,
  input  wire logic [19:0]              xlat_frame,
  output logic                          xlat_enable,
  output logic                          xlat_base_sel,
  output logic [31:0]                   xlat_base,
  output logic                          xlat_super_check,
  output logic [31:0]                   xlat_paddr
);

  // ==========================================================
  // helpers
  // ==========================================================
  // protection outranks invalid entries in the cause code
  function automatic logic [1:0] encode_cause(input logic p, input logic l1, input logic l2);
    if (p) begin
      encode_cause = mmu_regs_pkg::CAUSE_PROT;
    end else if (l1) begin
      encode_cause = mmu_regs_pkg::CAUSE_L1;
    end else if (l2) begin
      encode_cause = mmu_regs_pkg::CAUSE_L2;
    end else begin
      encode_cause = mmu_regs_pkg::CAUSE_NONE;
    end
  endfunction

  // base registers drop the page offset bits
  function automatic logic [31:0] align_base(input logic [31:0] d);
    align_base = {d[31:mmu_regs_pkg::OFFSET_W], {mmu_regs_pkg::OFFSET_W{1'b0}}};
  endfunction

  // ==========================================================
  // register state
  // ==========================================================
  logic [31:0] base_zero_ff, nxt_base_zero;
  logic [31:0] base_one_ff,  nxt_base_one;
  logic [31:0] fault_addr_ff, nxt_fault_addr;
  logic [3:0]  control_ff, nxt_control;
  logic [7:0]  status_ff,  nxt_status;
  logic        ack_ff, nxt_ack;
  logic        undef_ff, nxt_undef;
  logic        abort_ff, nxt_abort;
  logic [31:0] rdata_ff, nxt_rdata;
  mmu_regs_pkg::purge_cmd_t purge_ff, nxt_purge;

  logic access;
  logic wr;
  logic fault_take;
  logic refused;
  logic purge_wr;

  // accesses only reach the unit when mm instructions are enabled
  assign access     = mmr_req.valid && mm_insn_enable;
  assign wr         = access && mmr_req.write;
  // prefetch faults that are later discarded arrive with needed low
  assign fault_take = fault.valid && fault.needed;
  // a request while mm instructions are off is trapped, never acknowledged
  assign refused    = mmr_req.valid && !mm_insn_enable;
  // any write landing on one of the two purge registers
  assign purge_wr   = wr && (mmr_req.sel == mmu_regs_pkg::SEL_PURGE_ZERO ||
                             mmr_req.sel == mmu_regs_pkg::SEL_PURGE_ONE);

  // next-state for registers, purges and answers
  always_comb begin
    nxt_base_zero  = base_zero_ff;
    nxt_base_one   = base_one_ff;
    nxt_fault_addr = fault_addr_ff;
    nxt_control    = control_ff;
    nxt_status     = status_ff;
    nxt_ack        = access;
    nxt_undef      = refused;
    nxt_abort      = fault_take;
    nxt_rdata      = rdata_ff;
    nxt_purge      = '0;
    if (wr) begin
      case (mmr_req.sel)
        mmu_regs_pkg::SEL_BASE_ZERO: begin
          nxt_base_zero  = align_base(mmr_req.wdata);
          nxt_purge.by_base = 1'b1;
          nxt_purge.space   = 1'b0;
          nxt_purge.addr    = base_zero_ff;
        end
        mmu_regs_pkg::SEL_BASE_ONE: begin
          nxt_base_one   = align_base(mmr_req.wdata);
          nxt_purge.by_base = 1'b1;
          nxt_purge.space   = 1'b1;
          nxt_purge.addr    = base_one_ff;
        end
        mmu_regs_pkg::SEL_PURGE_ZERO: begin
          nxt_purge.by_vaddr = 1'b1;
          nxt_purge.space    = 1'b0;
          nxt_purge.addr     = mmr_req.wdata;
        end
        mmu_regs_pkg::SEL_PURGE_ONE: begin
          nxt_purge.by_vaddr = 1'b1;
          nxt_purge.space    = 1'b1;
          nxt_purge.addr     = mmr_req.wdata;
        end
        mmu_regs_pkg::SEL_FAULT_ADDR: begin
          nxt_fault_addr = mmr_req.wdata;
        end
        mmu_regs_pkg::SEL_CONTROL: begin
          // enable changes never touch the tlb
          nxt_control = mmr_req.wdata[mmu_regs_pkg::CTL_W-1:0];
        end
        mmu_regs_pkg::SEL_STATUS: begin
          nxt_status = mmr_req.wdata[mmu_regs_pkg::ST_W-1:0];
        end
        default: begin
          nxt_control = control_ff;
        end
      endcase
    end
    // a fault in the same cycle as a software write wins
    if (fault_take) begin
      nxt_fault_addr = fault.vaddr;
      nxt_status[mmu_regs_pkg::ST_CAUSE_LO +: 2] =
        encode_cause(fault.prot, fault.pte1_bad, fault.pte2_bad);
      nxt_status[mmu_regs_pkg::ST_DIR]    = fault.write;
      nxt_status[mmu_regs_pkg::ST_ORIGIN] = fault.user;
      // recorded as given; meaningless for interrupt acknowledge cycles
      nxt_status[mmu_regs_pkg::ST_CYCLE_LO +: 4] = fault.cycle;
    end
    if (access && !mmr_req.write) begin
      case (mmr_req.sel)
        mmu_regs_pkg::SEL_BASE_ZERO:  nxt_rdata = base_zero_ff;
        mmu_regs_pkg::SEL_BASE_ONE:   nxt_rdata = base_one_ff;
        mmu_regs_pkg::SEL_FAULT_ADDR: nxt_rdata = fault_addr_ff;
        mmu_regs_pkg::SEL_CONTROL:    nxt_rdata = {28'h0000000, control_ff};
        mmu_regs_pkg::SEL_STATUS:     nxt_rdata = {24'h000000, status_ff};
        default:                      nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register stage; control comes up with translation off
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      base_zero_ff  <= mmu_regs_pkg::ADDR_RESET;
      base_one_ff   <= mmu_regs_pkg::ADDR_RESET;
      fault_addr_ff <= mmu_regs_pkg::ADDR_RESET;
      control_ff    <= mmu_regs_pkg::CTL_RESET;
      status_ff     <= mmu_regs_pkg::ST_RESET;
      ack_ff        <= 1'b0;
      undef_ff      <= 1'b0;
      abort_ff      <= 1'b0;
      rdata_ff      <= 32'h0000_0000;
      purge_ff      <= '0;
    end else begin
      base_zero_ff  <= nxt_base_zero;
      base_one_ff   <= nxt_base_one;
      fault_addr_ff <= nxt_fault_addr;
      control_ff    <= nxt_control;
      status_ff     <= nxt_status;
      ack_ff        <= nxt_ack;
      undef_ff      <= nxt_undef;
      abort_ff      <= nxt_abort;
      rdata_ff      <= nxt_rdata;
      purge_ff      <= nxt_purge;
    end
  end

  assign mmr_ack             = ack_ff;
  assign mmr_rdata           = rdata_ff;
  assign undefined_insn_trap = undef_ff;
  assign abort_trap          = abort_ff;
  assign purge               = purge_ff;

  // ==========================================================
  // translation steering
  // ==========================================================
  // combinational from registered control so a lookup sees it at once
  always_comb begin
    xlat_enable = xlat_user ? control_ff[mmu_regs_pkg::CTL_USER]
                            : control_ff[mmu_regs_pkg::CTL_SUPER];
    xlat_base_sel = xlat_user && control_ff[mmu_regs_pkg::CTL_DUAL];
    xlat_base = xlat_base_sel ? base_one_ff : base_zero_ff;
    xlat_super_check = !xlat_user || control_ff[mmu_regs_pkg::CTL_OVERRIDE];
    // offset passes through; frame replaces the page number
    xlat_paddr = xlat_enable ? {xlat_frame, xlat_vaddr[mmu_regs_pkg::OFFSET_W-1:0]}
                             : xlat_vaddr;
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_fault_taken;
    fault.valid && fault.needed;
  endsequence

  sequence s_write_sel(logic [2:0] s);
    mmr_req.valid && mm_insn_enable && mmr_req.write && mmr_req.sel == s;
  endsequence

  a_base_low_zero: assert property (
    base_zero_ff[11:0] == 12'h000 && base_one_ff[11:0] == 12'h000)
    else $error("base register low bits not zero");

  a_base_purge_old: assert property (
    s_write_sel(mmu_regs_pkg::SEL_BASE_ONE) |=>
      purge.by_base && purge.space && purge.addr == $past(base_one_ff))
    else $error("base load did not purge old base");

  a_base0_purge_old: assert property (
    s_write_sel(mmu_regs_pkg::SEL_BASE_ZERO) |=>
      purge.by_base && !purge.space && purge.addr == $past(base_zero_ff))
    else $error("base zero load did not purge old base");

  a_vaddr_purge: assert property (
    s_write_sel(mmu_regs_pkg::SEL_PURGE_ZERO) |=>
      purge.by_vaddr && !purge.space && purge.addr == $past(mmr_req.wdata) ##1
      (purge.by_vaddr == $past(purge_wr)))
    else $error("purge write wrong or not one cycle");

  a_vaddr_purge_one: assert property (
    s_write_sel(mmu_regs_pkg::SEL_PURGE_ONE) |=>
      purge.by_vaddr && purge.space && purge.addr == $past(mmr_req.wdata))
    else $error("purge one write wrong");

  a_ctrl_no_purge: assert property (
    s_write_sel(mmu_regs_pkg::SEL_CONTROL) |=> !purge.by_base && !purge.by_vaddr)
    else $error("control write purged tlb");

  a_fault_capture: assert property (
    s_fault_taken |=> fault_addr_ff == $past(fault.vaddr) && abort_trap)
    else $error("fault address not captured");

  // no abort without a fault on a needed reference
  a_abort_needed: assert property (
    !fault_take |=> !abort_trap)
    else $error("abort without needed fault");

  a_ack_only_access: assert property (
    !access |=> !mmr_ack)
    else $error("ack without accepted request");

  a_prefetch_hold: assert property (
    fault.valid && !fault.needed && !wr |=> $stable(fault_addr_ff) && $stable(status_ff))
    else $error("discarded prefetch changed fault state");

  a_ctrl_read_zero: assert property (
    access && !mmr_req.write && mmr_req.sel == mmu_regs_pkg::SEL_CONTROL |=>
      mmr_ack && mmr_rdata[31:4] == 28'h0000000)
    else $error("control upper bits nonzero");

  a_status_read_zero: assert property (
    access && !mmr_req.write && mmr_req.sel == mmu_regs_pkg::SEL_STATUS |=>
      mmr_rdata[31:8] == 24'h000000)
    else $error("status upper bits nonzero");

  a_cause_prio: assert property (
    s_fault_taken ##0 fault.prot |=> status_ff[1:0] == mmu_regs_pkg::CAUSE_PROT)
    else $error("protection not reported");

  a_status_fields: assert property (
    s_fault_taken |=> status_ff[2] == $past(fault.write) && status_ff[3] == $past(fault.user))
    else $error("direction or origin wrong");

  a_dual_space: assert property (
    xlat_user && control_ff[2] |-> xlat_base == base_one_ff)
    else $error("dual space base wrong");

  a_single_space: assert property (
    !(xlat_user && control_ff[mmu_regs_pkg::CTL_DUAL]) |-> xlat_base == base_zero_ff)
    else $error("base zero not selected");

  a_undef_trap: assert property (
    refused |=> undefined_insn_trap && !mmr_ack ##1 (undefined_insn_trap == $past(refused)))
    else $error("disabled insn not trapped");

endmodule // mmu_control_status_regs

/* File: test/core_model.sv */
`timescale 1ns/1ps
// ==========================================================
// core side: issues mm register instructions and fault reports
module core_model (
  input  wire logic                 core_clk,
  output logic                      mm_insn_enable,
  output mmu_regs_pkg::mmr_req_t    mmr_req,
  output mmu_regs_pkg::fault_rpt_t  fault,
  output logic                      xlat_user,
  output logic [31:0]               xlat_vaddr,
  output logic [19:0]               xlat_frame
);
  // idle values at time zero
  initial begin
    mm_insn_enable = 1'b1;
    mmr_req        = '0;
    fault          = '0;
    xlat_user      = 1'b0;
    xlat_vaddr     = 32'h0000_0000;
    xlat_frame     = 20'h00000;
  end

  // one-cycle request; released data is inverted so a stale value never looks valid
  task automatic reg_op(input logic wr, input logic [2:0] sel, input logic [31:0] d);
    @(negedge core_clk);
    mmr_req <= {1'b1, wr, sel, d};
    @(negedge core_clk);
    mmr_req.valid <= 1'b0;
    mmr_req.wdata <= ~d;
  endtask

  // configuration enable for mm instructions, changed at a falling edge
  task automatic set_enable(input logic e);
    mm_insn_enable = e;
  endtask

  // reference mode and address parts for the combinational translation path
  task automatic set_xlat(input logic u, input logic [31:0] va, input logic [19:0] fr);
    xlat_user  = u;
    xlat_vaddr = va;
    xlat_frame = fr;
  endtask

  // one-cycle fault report from the translation logic
  task automatic send_fault(input mmu_regs_pkg::fault_rpt_t f);
    @(negedge core_clk);
    fault <= f;
    @(negedge core_clk);
    fault.valid <= 1'b0;
    fault.vaddr <= ~f.vaddr;
  endtask
endmodule // core_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
// ==========================================================
// bench top: core model on the far side, checks at falling edges
module testbench;
  logic                     core_clk = 1'b0;
  logic                     nrst     = 1'b0;
  logic                     mm_insn_enable;
  mmu_regs_pkg::mmr_req_t   mmr_req;
  mmu_regs_pkg::fault_rpt_t fault;
  mmu_regs_pkg::purge_cmd_t purge;
  logic                     mmr_ack;
  logic [31:0]              mmr_rdata;
  logic                     undefined_insn_trap;
  logic                     abort_trap;
  logic                     xlat_user;
  logic [31:0]              xlat_vaddr;
  logic [19:0]              xlat_frame;
  logic                     xlat_enable;
  logic                     xlat_base_sel;
  logic [31:0]              xlat_base;
  logic                     xlat_super_check;
  logic [31:0]              xlat_paddr;
  int                       error_cnt  = 0;
  int                       num_checks = 0;

  always #5 core_clk = ~core_clk;

  core_model core_u (.core_clk(core_clk), .mm_insn_enable(mm_insn_enable), .mmr_req(mmr_req), .fault(fault),
    .xlat_user(xlat_user), .xlat_vaddr(xlat_vaddr), .xlat_frame(xlat_frame));

  mmu_control_status_regs dut_u (.core_clk(core_clk), .nrst(nrst), .mm_insn_enable(mm_insn_enable),
    .mmr_req(mmr_req), .mmr_ack(mmr_ack), .mmr_rdata(mmr_rdata), .undefined_insn_trap(undefined_insn_trap),
    .fault(fault), .abort_trap(abort_trap), .purge(purge), .xlat_user(xlat_user), .xlat_vaddr(xlat_vaddr),
    .xlat_frame(xlat_frame), .xlat_enable(xlat_enable), .xlat_base_sel(xlat_base_sel), .xlat_base(xlat_base),
    .xlat_super_check(xlat_super_check), .xlat_paddr(xlat_paddr));

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ack lands at the rising edge that samples the request, seen at the following falling edge
  task automatic wr(input logic [2:0] sel, input logic [31:0] d);
    core_u.reg_op(1'b1, sel, d);
    check("write ack", 32'(mmr_ack), 32'h1);
  endtask

  task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
    core_u.reg_op(1'b0, sel, 32'h0000_0000);
    check("read ack", 32'(mmr_ack), 32'h1);
    check("read data", mmr_rdata, exp);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    for (int s = 0; s < 8; s++) rd(3'(s), 32'h0000_0000);
    check("enable after reset", 32'(xlat_enable), 32'h0);
    $display("test reset done");
  endtask

  task automatic test_base();
    wr(mmu_regs_pkg::SEL_BASE_ZERO, 32'hFFFF_FFFF);
    check("base purge flags", 32'({purge.by_vaddr, purge.by_base, purge.space}), 32'h2);
    check("base purge old", purge.addr, 32'h0000_0000);
    rd(mmu_regs_pkg::SEL_BASE_ZERO, 32'hFFFF_F000);
    wr(mmu_regs_pkg::SEL_BASE_ZERO, 32'h1234_5ABC);
    check("base purge old 2", purge.addr, 32'hFFFF_F000);
    wr(mmu_regs_pkg::SEL_BASE_ONE, 32'h0ABC_DFFF);
    check("base1 purge flags", 32'({purge.by_vaddr, purge.by_base, purge.space}), 32'h3);
    rd(mmu_regs_pkg::SEL_BASE_ONE, 32'h0ABC_D000);
    $display("test base done");
  endtask

  task automatic test_purge();
    for (int i = 0; i < 2; i++) begin
      wr(3'(mmu_regs_pkg::SEL_PURGE_ZERO + i), 32'hCAFE_0123 ^ i);
      check("purge flags", 32'({purge.by_vaddr, purge.by_base, purge.space}), 32'h4 | i);
      check("purge addr", purge.addr, 32'hCAFE_0123 ^ i);
      rd(3'(mmu_regs_pkg::SEL_PURGE_ZERO + i), 32'h0000_0000);
    end
    $display("test purge done");
  endtask

  // upper control and status bits are dropped on write and read back zero
  task automatic test_widths();
    wr(mmu_regs_pkg::SEL_CONTROL, 32'hFFFF_FFFF);
    rd(mmu_regs_pkg::SEL_CONTROL, 32'h0000_000F);
    wr(mmu_regs_pkg::SEL_CONTROL, 32'h0000_0000);
    check("no purge on disable", 32'({purge.by_vaddr, purge.by_base}), 32'h0);
    wr(mmu_regs_pkg::SEL_STATUS, 32'hFFFF_FFFF);
    rd(mmu_regs_pkg::SEL_STATUS, 32'h0000_00FF);
    $display("test widths done");
  endtask

  // every control setting against both privilege modes
  task automatic test_xlat();
    logic en;
    logic bs;
    for (int c = 0; c < 16; c++) begin
      wr(mmu_regs_pkg::SEL_CONTROL, 32'(c));
      for (int u = 0; u < 2; u++) begin
        @(negedge core_clk);
        core_u.set_xlat(u[0], 32'h89AB_C5D7 ^ c, 20'(20'h3F2E1 ^ c));
        #1;
        en = u[0] ? c[0] : c[1];
        bs = c[2] & u[0];
        check("xlat enable", 32'(xlat_enable), 32'(en));
        check("base sel", 32'(xlat_base_sel), 32'(bs));
        check("base value", xlat_base, bs ? 32'h0ABC_D000 : 32'h1234_5000);
        check("super check", 32'(xlat_super_check), 32'(!u[0] | c[3]));
        check("paddr", xlat_paddr, en ? {20'(20'h3F2E1 ^ c), 12'h5D7 ^ 12'(c)} : 32'h89AB_C5D7 ^ c);
      end
    end
    $display("test xlat done");
  endtask

  task automatic test_fault();
    logic [3:0] cyc [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    logic [2:0] bad [5] = '{3'b100, 3'b010, 3'b111, 3'b011, 3'b100};
    logic [1:0] cause;
    mmu_regs_pkg::fault_rpt_t f;
    for (int i = 0; i < 5; i++) begin
      f = {2'b11, bad[i], i[0], i[1], cyc[i], 32'hFEDC_BA98 ^ i};
      core_u.send_fault(f);
      check("abort", 32'(abort_trap), 32'h1);
      cause = bad[i][0] ? 2'h3 : (bad[i][2] ? 2'h1 : 2'h2);
      rd(mmu_regs_pkg::SEL_STATUS, 32'({cyc[i], i[1], i[0], cause}));
      rd(mmu_regs_pkg::SEL_FAULT_ADDR, 32'hFEDC_BA98 ^ i);
    end
    f = {2'b10, 3'b111, 2'b11, 4'h9, 32'h0123_4567};
    core_u.send_fault(f);
    check("no abort", 32'(abort_trap), 32'h0);
    rd(mmu_regs_pkg::SEL_STATUS, 32'h0000_00C1);
    rd(mmu_regs_pkg::SEL_FAULT_ADDR, 32'hFEDC_BA9C);
    $display("test fault done");
  endtask

  task automatic test_disabled();
    @(negedge core_clk);
    core_u.set_enable(1'b0);
    core_u.reg_op(1'b1, mmu_regs_pkg::SEL_CONTROL, 32'h0000_0003);
    check("undef trap", 32'({undefined_insn_trap, mmr_ack}), 32'h2);
    core_u.set_enable(1'b1);
    rd(mmu_regs_pkg::SEL_CONTROL, 32'h0000_000F);
    $display("test disabled done");
  endtask

  // a second reset in mid-run must bring control back with translation off
  task automatic test_reset_again();
    @(negedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(negedge core_clk);
    nrst <= 1'b1;
    check("enable in reset", 32'(xlat_enable), 32'h0);
    rd(mmu_regs_pkg::SEL_CONTROL, 32'h0000_0000);
    $display("test reset again done");
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (5) @(negedge core_clk);
    nrst <= 1'b1;
    test_reset();
    test_base();
    test_purge();
    test_widths();
    test_xlat();
    test_fault();
    test_disabled();
    test_reset_again();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
endmodule // testbench
